// >>> hw/apdc_defines.vh
// Constants for the converter standby and power-down control block.
// Assumes a 20 MHz core clock; all times are given in their own unit first.
`ifndef APDC_DEFINES_VH
`define APDC_DEFINES_VH
// Core clock period in ns.
`define APDC_CLK_NS 50
// Nominal converter clock in Hz, reference for all scaled times.
`define APDC_NOM_FCLK_HZ 4915200
// Data ready after standby with calibration, in ms.
`define APDC_T_CAL_FAST_MS 103
`define APDC_T_CAL_SLOW_MS 803
// Wake-up after power-down, in ns (internal, external) and us (crystal).
`define APDC_T_WAKE_INT_NS 7950
`define APDC_T_WAKE_EXT_NS 160
`define APDC_T_WAKE_XTAL_US 5600
// Cycle counts derived from the times (all times round down, each at least one).
`define APDC_CYC_CAL_FAST (`APDC_T_CAL_FAST_MS * 1000000 / `APDC_CLK_NS)
`define APDC_CYC_CAL_SLOW (`APDC_T_CAL_SLOW_MS * 1000000 / `APDC_CLK_NS)
`define APDC_CYC_WAKE_INT (`APDC_T_WAKE_INT_NS / `APDC_CLK_NS)
`define APDC_CYC_WAKE_EXT ((`APDC_T_WAKE_EXT_NS / `APDC_CLK_NS) + 0)
`define APDC_CYC_WAKE_XTAL (`APDC_T_WAKE_XTAL_US * 1000 / `APDC_CLK_NS)
// Serial clock pulses that arm the calibration request.
`define APDC_CAL_SCLKS 25
// Result bits in one readout.
`define APDC_DATA_BITS 24
// Clock source codes.
`define APDC_SRC_INT 2'h0
`define APDC_SRC_EXT 2'h1
`define APDC_SRC_XTAL 2'h2
`endif

// >>> hw/apdc_sync.v
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs asynchronous to clk; output is the second flop only.
`timescale 1ns/1ns
`default_nettype none
module apdc_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Asynchronous level in, synchronised level out.
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // The first stage feeds the second stage and nothing else.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule
`default_nettype wire

// >>> hw/apdc_top.v
// Power-mode control of a delta-sigma converter: standby with offset
// calibration on wake, and power-down acting as a full reset.
// Assumes the host drives the serial clock and the active-low power-down pin.
// Overview of operation
// - On leaving that standby the converter calibrates offset before any result.
// - Data ready 103 ms (rate high) or 803 ms (rate low) after standby exit.
// - Wake and data-ready intervals scale with the converter clock period.
// - First result after calibrated standby is fully settled and usable.
// - Power-down pin low shuts down all circuitry and holds power-down.
// - Entering power-down resets the whole converter to a known state.
// - Power-down may be asserted mid-readout without shifting all 24 bits.
// - Wake after power-down: 7.95 us internal, 0.16 us external, 5.6 ms crystal.
`timescale 1ns/1ns
`default_nettype none
`include "apdc_defines.vh"
module apdc_top #(
  parameter CAL_FAST_CYC = `APDC_CYC_CAL_FAST,
  parameter CAL_SLOW_CYC = `APDC_CYC_CAL_SLOW,
  parameter WAKE_XTAL_CYC = `APDC_CYC_WAKE_XTAL,
  parameter CNT_W = 26
) (
  // Core clock and reset.
  input wire CORE_CLK,
  input wire SYS_RST,
  // Host pins.
  input wire SERIAL_CLK,
  input wire POWER_OFF_PIN_N,
  // Straps and supply presence.
  input wire RATE_HIGH,
  input wire [1:0] CLK_SOURCE,
  input wire ANALOG_SUPPLY,
  input wire DIGITAL_SUPPLY,
  // Converter clock period scale, 256 = nominal period.
  input wire [9:0] CLK_PERIOD_SCALE,
  // Status toward the converter core.
  output reg POWERED_DOWN,
  output reg STANDBY,
  output reg CALIBRATING,
  output reg DATA_READY,
  output reg RESULT_SETTLED,
  output reg CORE_RESET
);
  // ****************************************************************
  // State codes
  // ****************************************************************
  localparam [2:0] ST_POWER_OFF_PIN_N = 3'h0;
  localparam [2:0] ST_WAKE = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_STBY = 3'h3;
  localparam [2:0] ST_CAL = 3'h4;
  // Sized copies of the counts, so that no assignment pads or drops bits.
  localparam [CNT_W+9:0] CAL_FAST_X = CAL_FAST_CYC;
  localparam [CNT_W+9:0] CAL_SLOW_X = CAL_SLOW_CYC;
  localparam [CNT_W+9:0] WAKE_XTAL_X = WAKE_XTAL_CYC;
  localparam [CNT_W+9:0] WAKE_EXT_X = `APDC_CYC_WAKE_EXT;
  localparam [CNT_W+9:0] WAKE_INT_X = `APDC_CYC_WAKE_INT;
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  // The rise that starts the high hold comes after the pulses and is counted too.
  localparam [5:0] CAL_EDGES = `APDC_CAL_SCLKS + 1;
  localparam [5:0] CLEAR_EDGES = `APDC_DATA_BITS + 2;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire [4:0] pins_s;
  apdc_sync #(.W(5), .INIT(5'h00)) u_sync (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .d({SERIAL_CLK, POWER_OFF_PIN_N, RATE_HIGH, ANALOG_SUPPLY, DIGITAL_SUPPLY}),
    .q(pins_s)
  );
  wire sclk_s = pins_s[4];
  wire power_off_pin_n_n_s = pins_s[3];
  wire rate_s = pins_s[2];
  // Supplies must both be up before a release is honoured.
  wire supplies_ok = pins_s[1] & pins_s[0];
  wire run_ok = power_off_pin_n_n_s & supplies_ok;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] cnt_nxt;
  reg [5:0] edges_r;
  reg [5:0] edges_nxt;
  reg sclk_d_r;
  reg cal_req_r;
  reg cal_req_nxt;
  reg [CNT_W-1:0] hold_r;
  reg [CNT_W-1:0] hold_nxt;

  // ****************************************************************
  // Scaled interval targets
  // ****************************************************************
  // The products are wide so that slow clocks do not overflow.
  wire [CNT_W+9:0] cal_base = rate_s ? CAL_FAST_X : CAL_SLOW_X;
  wire [CNT_W+9:0] cal_scaled = (cal_base * CLK_PERIOD_SCALE) >> 8;
  reg [CNT_W+9:0] wake_base;
  always @* begin
    case (CLK_SOURCE)
      `APDC_SRC_EXT: wake_base = WAKE_EXT_X;
      `APDC_SRC_XTAL: wake_base = WAKE_XTAL_X;
      default: wake_base = WAKE_INT_X;
    endcase
  end
  wire [CNT_W+9:0] wake_scaled = (wake_base * CLK_PERIOD_SCALE) >> 8;
  // Never less than one cycle, whatever the scale.
  wire [CNT_W-1:0] cal_tgt = (~|cal_scaled) ? CNT_ONE : cal_scaled[CNT_W-1:0];
  wire [CNT_W-1:0] wake_tgt = (~|wake_scaled) ? CNT_ONE : wake_scaled[CNT_W-1:0];

  wire sclk_rise = sclk_s & ~sclk_d_r;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Standby is taken once the clock has stayed high past the activation
  // window; the wait here reuses the wake target as a simple hold time.
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    edges_nxt = edges_r;
    cal_req_nxt = cal_req_r;
    hold_nxt = hold_r;
    case (state_r)
      ST_POWER_OFF_PIN_N: begin
        cnt_nxt = CNT_ZERO;
        // A stale hold count must not survive into the next wake.
        hold_nxt = CNT_ZERO;
        edges_nxt = 6'h00;
        cal_req_nxt = 1'b0;
        if (run_ok) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r + 1'b1 >= wake_tgt) begin
          state_nxt = ST_RUN;
          cnt_nxt = CNT_ZERO;
        end
      end
      ST_RUN: begin
        if (sclk_rise && edges_r != 6'h3f) begin
          edges_nxt = edges_r + 6'h01;
        end
        if (sclk_s) begin
          hold_nxt = hold_r + 1'b1;
        end else begin
          hold_nxt = CNT_ZERO;
        end
        // A long high level after the clocks means standby.
        if (sclk_s && hold_r >= wake_tgt + CNT_ONE) begin
          state_nxt = ST_STBY;
          cal_req_nxt = (edges_r == CAL_EDGES);
        end else if (!sclk_s && hold_r == CNT_ZERO && edges_r >= CLEAR_EDGES) begin
          edges_nxt = 6'h00;
        end
      end
      ST_STBY: begin
        hold_nxt = CNT_ZERO;
        edges_nxt = 6'h00;
        if (!sclk_s) begin
          cnt_nxt = CNT_ZERO;
          state_nxt = cal_req_r ? ST_CAL : ST_RUN;
        end
      end
      ST_CAL: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r + 1'b1 >= cal_tgt) begin
          state_nxt = ST_RUN;
          cal_req_nxt = 1'b0;
          cnt_nxt = CNT_ZERO;
        end
      end
      default: state_nxt = ST_POWER_OFF_PIN_N;
    endcase
    // Power-down overrides everything, including a readout in progress.
    if (!run_ok) begin
      state_nxt = ST_POWER_OFF_PIN_N;
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= ST_POWER_OFF_PIN_N;
      cnt_r <= {CNT_W{1'b0}};
      edges_r <= 6'h00;
      sclk_d_r <= 1'b0;
      cal_req_r <= 1'b0;
      hold_r <= {CNT_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      edges_r <= edges_nxt;
      sclk_d_r <= sclk_s;
      cal_req_r <= cal_req_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The ready pulse after calibration marks a settled first result.
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      POWERED_DOWN <= 1'b1;
      STANDBY <= 1'b0;
      CALIBRATING <= 1'b0;
      DATA_READY <= 1'b0;
      RESULT_SETTLED <= 1'b0;
      CORE_RESET <= 1'b1;
    end else begin
      POWERED_DOWN <= (state_nxt == ST_POWER_OFF_PIN_N);
      CORE_RESET <= (state_nxt == ST_POWER_OFF_PIN_N) || (state_nxt == ST_WAKE);
      STANDBY <= (state_nxt == ST_STBY);
      CALIBRATING <= (state_nxt == ST_CAL);
      DATA_READY <= (state_r == ST_CAL) && (state_nxt == ST_RUN);
      if (state_nxt == ST_POWER_OFF_PIN_N || state_nxt == ST_CAL) begin
        RESULT_SETTLED <= 1'b0;
      end else if (state_r == ST_CAL && state_nxt == ST_RUN) begin
        RESULT_SETTLED <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/apdc_host_model.sv
// Host model: drives serial clock, power-down pin and supplies.
// Assumes the core clock; all changes land on its falling edge.
`timescale 1ns/1ns
`default_nettype none
module apdc_host_model (
  // Core clock for pacing.
  input wire logic clk,
  // Pins toward the converter.
  output logic sclk,
  output logic pin_n,
  output logic asup,
  output logic dsup
);
  // Supplies off and pin low at start, as at power-up.
  initial begin
    sclk = 1'b0;
    pin_n = 1'b0;
    asup = 1'b0;
    dsup = 1'b0;
  end
  // Half of a 400 ns serial clock period.
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  // Supplies first, pin released only afterwards.
  task automatic power_up();
    asup = 1'b1;
    dsup = 1'b1;
    half();
    pin_n = 1'b1;
  endtask
  // Pin held low well beyond the minimum width.
  task automatic power_down();
    pin_n = 1'b0;
    repeat (540) @(negedge clk);
  endtask
  // Serial clock parked at a level, as when it is held high for standby.
  task automatic park(input logic v);
    sclk = v;
  endtask
  // Clock pulses; serial clock stands low outside them.
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      half();
      sclk = 1'b0;
      half();
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/apdc_properties.sv
// Checker for the power-mode block, bound to its top module.
// Assumes the nominal clock period scale while a calibration runs.
`timescale 1ns/1ns
`default_nettype none
module apdc_properties #(
  parameter CAL_FAST_CYC = 40,
  parameter CAL_SLOW_CYC = 200
) (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Pins and straps.
  input wire logic POWER_OFF_PIN_N,
  input wire logic RATE_HIGH,
  input wire logic [1:0] CLK_SOURCE,
  // Status.
  input wire logic POWERED_DOWN,
  input wire logic STANDBY,
  input wire logic CALIBRATING,
  input wire logic DATA_READY,
  input wire logic RESULT_SETTLED,
  input wire logic CORE_RESET
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // *****
  // Calibration run length, counted so the ready pulse can be timed.
  // *****
  logic [31:0] cal_n_r;
  logic [31:0] cal_tgt;
  assign cal_tgt = RATE_HIGH ? CAL_FAST_CYC : CAL_SLOW_CYC;
  // Cleared whenever calibration is not running.
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) cal_n_r <= 32'h0;
    else cal_n_r <= CALIBRATING ? cal_n_r + 32'h1 : 32'h0;
  end
  a_pd_enters: assert property ($fell(POWER_OFF_PIN_N) |-> ##[1:5] POWERED_DOWN)
    else $error("power-down not entered after pin low");
  a_pd_resets: assert property (POWERED_DOWN |-> CORE_RESET && !RESULT_SETTLED)
    else $error("power-down without core reset");
  a_pd_quiet: assert property (POWERED_DOWN |-> !STANDBY && !CALIBRATING && !DATA_READY)
    else $error("activity while powered down");
  a_cal_first: assert property (DATA_READY |-> $past(CALIBRATING))
    else $error("data ready without calibration");
  a_ready_pulse: assert property (DATA_READY |=> !DATA_READY)
    else $error("data ready longer than one cycle");
  a_settled_rise: assert property ($rose(RESULT_SETTLED) |-> DATA_READY)
    else $error("settled flag rose without data ready");
  a_cal_time: assert property (DATA_READY |-> cal_n_r + 1 >= cal_tgt && cal_n_r <= cal_tgt + 1)
    else $error("calibration length wrong");
  a_wake_ext: assert property ($fell(POWERED_DOWN) && CLK_SOURCE == 2'h1 |-> ##[1:8] !CORE_RESET)
    else $error("external clock wake too slow");
endmodule
bind apdc_top apdc_properties #(.CAL_FAST_CYC(CAL_FAST_CYC), .CAL_SLOW_CYC(CAL_SLOW_CYC)) u_chk (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .POWER_OFF_PIN_N(POWER_OFF_PIN_N),
  .RATE_HIGH(RATE_HIGH), .CLK_SOURCE(CLK_SOURCE), .POWERED_DOWN(POWERED_DOWN),
  .STANDBY(STANDBY), .CALIBRATING(CALIBRATING), .DATA_READY(DATA_READY),
  .RESULT_SETTLED(RESULT_SETTLED), .CORE_RESET(CORE_RESET));
`default_nettype wire

// >>> tb/tb_top.sv
// Testbench for the power-mode block with the host model.
// Assumes shortened calibration and crystal counts set below.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst = 1'b1, rate = 1'b1;
  logic [1:0] src = 2'h1;
  logic [9:0] scale = 10'h100;
  logic sclk, pin_n, asup, dsup, pd, sb, cal, rdy, setl, crst;
  int err_total = 0, checked = 0, cyc = 0, n;
  always #25 clk = ~clk;
  apdc_host_model host (.clk(clk), .sclk(sclk), .pin_n(pin_n), .asup(asup), .dsup(dsup));
  apdc_top #(.CAL_FAST_CYC(40), .CAL_SLOW_CYC(200), .WAKE_XTAL_CYC(30)) DUT (
    .CORE_CLK(clk), .SYS_RST(rst), .SERIAL_CLK(sclk), .POWER_OFF_PIN_N(pin_n),
    .RATE_HIGH(rate), .CLK_SOURCE(src), .ANALOG_SUPPLY(asup), .DIGITAL_SUPPLY(dsup),
    .CLK_PERIOD_SCALE(scale), .POWERED_DOWN(pd), .STANDBY(sb), .CALIBRATING(cal),
    .DATA_READY(rdy), .RESULT_SETTLED(setl), .CORE_RESET(crst));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Wake time from power-down exit to end of core reset, plus or minus one.
  task automatic t_wake(input logic [1:0] s, input logic [9:0] k, input int tgt);
    src = s;
    scale = k;
    host.power_down();
    check("pd_state", {pd, crst}, 2'h3);
    host.power_up();
    n = 0;
    while (pd === 1'b1 && n < 50) begin @(negedge clk); n++; end
    n = 0;
    while (crst !== 1'b0 && n < 400) begin @(negedge clk); n++; end
    check("wake", n >= tgt - 1 && n <= tgt + 1, 1);
  endtask
  // Standby with or without the calibration request.
  // The settled flag stays as it was when no calibration runs.
  task automatic t_stby(input int np, input logic r, input int tgt, input logic es);
    rate = r;
    host.pulses(np);
    host.park(1'b1);
    repeat (200) @(negedge clk);
    check("standby", sb, 1);
    host.park(1'b0);
    repeat (4) @(negedge clk);
    check("standby_exit", sb, 0);
    check("calibrating", cal, tgt > 0);
    check("settled_clr", setl, (tgt > 0) ? 1'b0 : es);
    n = 4;
    while (rdy !== 1'b1 && n < 260) begin @(negedge clk); n++; end
    if (tgt > 0) check("ready_time", n >= tgt && n <= tgt + 8, 1);
    else check("no_ready", rdy, 0);
    @(negedge clk);
    check("settled", setl, es);
  endtask
  // Power-down in mid readout drops the settled result.
  task automatic t_pd_mid();
    host.pulses(10);
    host.power_down();
    check("pd_mid", {pd, crst, setl}, 3'h6);
    host.power_up();
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_wake(2'h1, 10'h100, 3);
    t_wake(2'h0, 10'h100, 159);
    t_wake(2'h3, 10'h100, 159);
    t_wake(2'h2, 10'h100, 30);
    t_wake(2'h1, 10'h200, 6);
    scale = 10'h100;
    t_stby(25, 1'b1, 40, 1'b1);
    t_stby(25, 1'b0, 200, 1'b1);
    t_stby(24, 1'b1, 0, 1'b1);
    t_pd_mid();
    close_out();
  end
endmodule
`default_nettype wire
